// file: logic/iow_pkg.sv
// package for the io safety watchdog: constants and carrier types
package iow_pkg;
  // ------------------------------------------------------------
  // timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS     = 20;
  localparam logic [31:0] BITE_NS_RESET     = 32'h3B9ACA00;
  localparam logic [31:0] BITTEN_RESET      = 32'h0;

  // ------------------------------------------------------------
  // carriers
  // ------------------------------------------------------------
  // host access: every transfer passes through the watchdog gate
  typedef struct packed {
    logic        req;
    logic        wr;
    logic [15:0] addr;
    logic [31:0] wdata;
  } iow_host_req_type;

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
  } iow_host_rsp_type;
endpackage

// file: logic/iow_watchdog.sv
// io safety watchdog: service timer, bite latch, pin detach and host gate
`timescale 1ns/1ps
// Notes on behaviour
// - bite releases all pins to pulled-up inputs
// - bitten state blocks all host data exchange
// - bite touches pins and host link only; modules keep running
// - clearing bite restores host link and pins
// - bitten flag readable; host writes zero clears
// - timeout is 32-bit nanoseconds, read/write
// - timeout starts at one second
// - bite when elapsed time exceeds timeout; the timer idles from reset until a service or clear loads it
// - service reloads the full timeout period
module iow_watchdog
  import iow_pkg::*;
#(
  parameter int unsigned PIN_COUNT = 72
) (
  // clock and reset
  input  wire logic                 clk_sys,
  input  wire logic                 rst,
  // watchdog control from the host driver
  input  wire logic                 pet_pulse,
  input  wire logic                 timeout_wr,
  input  wire logic [31:0]          timeout_wdata,
  input  wire logic                 bitten_wr,
  input  wire logic                 bitten_wdata,
  output logic      [31:0]          bite_interval_nanos,
  output logic                      bitten,
  // host data path, gated by the watchdog
  input  wire iow_host_req_type     host_req,
  output iow_host_rsp_type          host_rsp,
  output iow_host_req_type          core_req,
  input  wire iow_host_rsp_type     core_rsp,
  // pins: function side and board side
  input  wire logic [PIN_COUNT-1:0] func_out,
  input  wire logic [PIN_COUNT-1:0] func_oe,
  output logic      [PIN_COUNT-1:0] func_in,
  output logic      [PIN_COUNT-1:0] pin_out,
  output logic      [PIN_COUNT-1:0] pin_oe,
  output logic      [PIN_COUNT-1:0] pin_pullup_en,
  input  wire logic [PIN_COUNT-1:0] pin_in
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  logic [31:0]          interval_r, interval_nxt;
  logic [31:0]          count_r,    count_nxt;
  logic                 bitten_r,   bitten_nxt;
  logic [PIN_COUNT-1:0] pin_s1_r,   pin_s1_nxt;
  logic [PIN_COUNT-1:0] pin_s2_r,   pin_s2_nxt;
  logic [31:0]          reload_cycles;
  logic                 expire;
  logic                 clear_req;

  // ------------------------------------------------------------
  // timeout register
  // ------------------------------------------------------------
  always_comb begin
    interval_nxt = interval_r;
    if (timeout_wr) begin
      interval_nxt = timeout_wdata;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      interval_r <= BITE_NS_RESET;
    end else begin
      interval_r <= interval_nxt;
    end
  end

  // ------------------------------------------------------------
  // service timer
  // ------------------------------------------------------------
  // whole periods plus one, so the bite lands only once the elapsed time
  // is strictly past the timeout; the quotient leaves room for the +1
  always_comb begin
    reload_cycles = (interval_r / 32'(CLK_PERIOD_NS)) + 32'h1;
  end

  always_comb begin
    expire    = !pet_pulse && (count_r == 32'h1);
    clear_req = bitten_wr && !bitten_wdata && bitten_r;
  end

  // timer idles at zero until the first service or a clear
  always_comb begin
    count_nxt = count_r;
    if (pet_pulse || clear_req) begin
      count_nxt = reload_cycles;
    end else if (count_r != 32'h0) begin
      count_nxt = count_r - 32'h1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      count_r <= 32'h0;
    end else begin
      count_r <= count_nxt;
    end
  end

  // ------------------------------------------------------------
  // bite flag
  // ------------------------------------------------------------
  always_comb begin
    bitten_nxt = bitten_r;
    if (clear_req) begin
      bitten_nxt = 1'b0;
    end
    if (bitten_wr && bitten_wdata) begin
      bitten_nxt = 1'b1;
    end
    // a bite wins over a clear landing in the same cycle
    if (expire) begin
      bitten_nxt = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bitten_r <= BITTEN_RESET[0];
    end else begin
      bitten_r <= bitten_nxt;
    end
  end

  // ------------------------------------------------------------
  // pin input synchroniser
  // ------------------------------------------------------------
  // board pins are asynchronous; only the second flop feeds the modules
  always_comb begin
    pin_s1_nxt = pin_in;
    pin_s2_nxt = pin_s1_r;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pin_s1_r <= '0;
      pin_s2_r <= '0;
    end else begin
      pin_s1_r <= pin_s1_nxt;
      pin_s2_r <= pin_s2_nxt;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  // while bitten the pins float high and the host sees nothing;
  // function modules keep their own state untouched
  always_comb begin
    bite_interval_nanos = interval_r;
    bitten              = bitten_r;
    pin_out             = bitten_r ? '0 : func_out;
    pin_oe              = bitten_r ? '0 : func_oe;
    pin_pullup_en       = {PIN_COUNT{bitten_r}};
    func_in             = pin_s2_r;
    core_req            = host_req;
    core_req.req        = host_req.req & ~bitten_r;
    host_rsp.ack        = core_rsp.ack & ~bitten_r;
    host_rsp.rdata      = bitten_r ? 32'h0 : core_rsp.rdata;
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  AST_PINS_RELEASED: assert property (@(posedge clk_sys) disable iff (rst)
    bitten |-> (pin_oe == '0 && pin_pullup_en == '1))
    else $error("pins driven while bitten");
  AST_HOST_BLOCKED: assert property (@(posedge clk_sys) disable iff (rst)
    bitten |-> (!core_req.req && !host_rsp.ack))
    else $error("host traffic while bitten");
  AST_PINS_PASS: assert property (@(posedge clk_sys) disable iff (rst)
    !bitten |-> (pin_oe == func_oe && pin_out == func_out))
    else $error("pins not restored");
  AST_CLEAR: assert property (@(posedge clk_sys) disable iff (rst)
    (bitten && bitten_wr && !bitten_wdata && !(count_r == 32'h1 && !pet_pulse))
      |=> !bitten)
    else $error("bitten flag not cleared");
  AST_TIMEOUT_WR: assert property (@(posedge clk_sys) disable iff (rst)
    timeout_wr |=> bite_interval_nanos == $past(timeout_wdata))
    else $error("timeout write lost");
  AST_BITE: assert property (@(posedge clk_sys) disable iff (rst)
    (count_r == 32'h1 && !pet_pulse) |=> bitten)
    else $error("expiry did not bite");
  AST_RELOAD: assert property (@(posedge clk_sys) disable iff (rst)
    pet_pulse |=> count_r == $past(reload_cycles))
    else $error("service did not reload");
  AST_COUNT: assert property (@(posedge clk_sys) disable iff (rst)
    (!pet_pulse && !bitten_wr && count_r > 32'h1) |=> count_r == $past(count_r) - 32'h1)
    else $error("timer not counting");
  AST_NO_EARLY: assert property (@(posedge clk_sys) disable iff (rst)
    (!bitten && count_r > 32'h1) |=> !bitten || $past(bitten_wr && bitten_wdata))
    else $error("bite before expiry");

  AST_IDLE: assert property (@(posedge clk_sys) disable iff (rst)
    (count_r == 32'h0 && !pet_pulse && !clear_req) |=> count_r == 32'h0)
    else $error("idle timer moved");

  AST_FORCE: assert property (@(posedge clk_sys) disable iff (rst)
    (bitten_wr && bitten_wdata) |=> bitten)
    else $error("forced bite lost");

  AST_SYNC: assert property (@(posedge clk_sys) disable iff (rst)
    1'b1 |=> func_in == $past(pin_s1_r))
    else $error("pin input not synchronised");

  AST_RESTORE: assert property (@(posedge clk_sys) disable iff (rst)
    $fell(bitten) |-> (core_req.req == host_req.req && host_rsp.ack == core_rsp.ack))
    else $error("host link not restored");

  AST_HOLD: assert property (@(posedge clk_sys) disable iff (rst)
    !timeout_wr |=> $stable(bite_interval_nanos))
    else $error("timeout changed without write");

endmodule // iow_watchdog

// file: tb/iow_host_model.sv
// host driver model: periodic service and bite clear
`timescale 1ns/1ps
module iow_host_model (
  // clock and control
  input  wire logic       clk_sys,
  input  wire logic       pet_en,
  input  wire logic [7:0] gap,
  input  wire logic       clr_en,
  input  wire logic       frc_en,
  input  wire logic       bitten,
  // watchdog control
  output logic            pet_pulse,
  output logic            bitten_wr,
  output logic            bitten_wdata
);
  int cnt = 0;
  initial pet_pulse = 1'b0;
  initial bitten_wr = 1'b0;
  initial bitten_wdata = 1'b0;
  // drives off the falling edge so the watchdog samples settled pulses
  always @(negedge clk_sys) begin
    pet_pulse    <= pet_en && cnt + 1 >= gap;
    cnt          <= (pet_en && cnt + 1 >= gap) ? 0 : cnt + 1;
    // zero clears a bite, one forces it; each write is a one-cycle pulse
    bitten_wr    <= !bitten_wr && ((clr_en && bitten) || (frc_en && !bitten));
    bitten_wdata <= frc_en && !bitten;
  end
endmodule // iow_host_model

// file: tb/io_safety_watchdog_tb.sv
// self-checking bench for the io safety watchdog
`timescale 1ns/1ps
module io_safety_watchdog_tb;
  import iow_pkg::*;
  logic             clk_sys = 0, rst = 1, timeout_wr = 0, pet_en = 0, clr_en = 0, frc_en = 0;
  logic             pet_pulse, bitten_wr, bitten_wdata, bitten;
  logic [7:0]       gap = 1, func_out = 0, func_oe = 0, pin_in = 0;
  logic [7:0]       func_in, pin_out, pin_oe, pin_pu, p1, p2;
  logic [31:0]      ns = 0, nanos;
  iow_host_req_type host_req = '0, core_req;
  iow_host_rsp_type host_rsp, core_rsp = '0;
  int               err_total = 0, num_checks = 0, since = 0, exp_cyc;

  initial forever #10 clk_sys = ~clk_sys;
  // cycles since the last taken service
  always @(posedge clk_sys) begin
    since <= pet_pulse ? 0 : since + 1;
  end
  // two-flop input history, cleared together with the design
  always @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      p1 <= 8'h00;
      p2 <= 8'h00;
    end else begin
      p1 <= pin_in;
      p2 <= p1;
    end
  end

  iow_watchdog #(.PIN_COUNT(8)) u_dut (.clk_sys(clk_sys), .rst(rst), .pet_pulse(pet_pulse),
    .timeout_wr(timeout_wr), .timeout_wdata(ns), .bitten_wr(bitten_wr),
    .bitten_wdata(bitten_wdata),
    .bite_interval_nanos(nanos), .bitten(bitten), .host_req(host_req), .host_rsp(host_rsp),
    .core_req(core_req), .core_rsp(core_rsp), .func_out(func_out), .func_oe(func_oe),
    .func_in(func_in), .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup_en(pin_pu),
    .pin_in(pin_in));
  iow_host_model u_host (.clk_sys(clk_sys), .pet_en(pet_en), .gap(gap), .clr_en(clr_en),
    .frc_en(frc_en), .bitten(bitten), .pet_pulse(pet_pulse), .bitten_wr(bitten_wr),
    .bitten_wdata(bitten_wdata));

  // first whole cycle count whose elapsed time is strictly past t
  function automatic int cyc_of(logic [31:0] t);
    return int'(t / 32'(CLK_PERIOD_NS)) + 1;
  endfunction

  task automatic cmp(string nm, logic [63:0] e, logic [63:0] g);
    num_checks++;
    if (g !== e) begin
      err_total++;
      $display("Error %s exp %h got %h", nm, e, g);
    end
  endtask

  task automatic tally_and_finish;
    $display("checks %0d errors %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // bounded wait; a hang ends the run
  task automatic wait_bit(logic v);
    for (int k = 0; k < 2000 && bitten !== v; k++) @(negedge clk_sys);
    if (bitten !== v) begin
      err_total++;
      tally_and_finish;
    end
  endtask

  // check gate and pins for bite state b, then new random traffic
  task automatic step(logic b);
    iow_host_req_type e;
    @(negedge clk_sys);
    e = host_req;
    if (b) e.req = 1'b0;
    cmp("core_req", e, core_req);
    cmp("host_rsp", b ? 33'h0 : 33'(core_rsp), host_rsp);
    cmp("pin_out", b ? 8'h00 : func_out, pin_out);
    cmp("pin_oe", b ? 8'h00 : func_oe, pin_oe);
    cmp("pin_pu", b ? 8'hFF : 8'h00, pin_pu);
    cmp("func_in", p2, func_in);
    cmp("bitten", b, bitten);
    host_req = 49'({$urandom, $urandom});
    core_rsp = 33'({$urandom, $urandom});
    {func_out, func_oe, pin_in} = 24'($urandom);
  endtask

  initial begin
    void'($urandom(32'h0846));
    repeat (12) @(negedge clk_sys);
    rst = 0;
    step(0);
    cmp("nanos", BITE_NS_RESET, nanos);
    for (int i = 0; i < 6; i++) begin
      // two shortest timeouts first, one landing off a cycle boundary
      ns = (i < 2) ? 32'(40 + i) : 32'(40 + $urandom % 600);
      exp_cyc = cyc_of(ns);
      pet_en <= 1;
      gap <= 1;
      timeout_wr = 1;
      step(0);
      timeout_wr = 0;
      step(0);
      cmp("nanos", ns, nanos);
      gap <= 8'(1 + $urandom % (exp_cyc - 1));
      repeat (3 * exp_cyc) step(0);
      pet_en <= 0;
      wait_bit(1);
      cmp("bite_cycles", exp_cyc, since);
      repeat (4) step(1);
      clr_en <= 1;
      wait_bit(0);
      clr_en <= 0;
      pet_en <= 1;
      gap <= 1;
      repeat (3) step(0);
    end
    // a reset in mid-run brings the timeout back to its load value
    rst = 1;
    repeat (2) @(negedge clk_sys);
    rst = 0;
    step(0);
    cmp("nanos", BITE_NS_RESET, nanos);
    // a write of one forces the bite while steady service runs
    frc_en <= 1;
    wait_bit(1);
    frc_en <= 0;
    step(1);
    clr_en <= 1;
    wait_bit(0);
    clr_en <= 0;
    step(0);
    tally_and_finish;
  end
endmodule // io_safety_watchdog_tb
